// >>> logic/lcd_key_ctrl_decode.sv
// LCD segment driver control decode with key-scan matrix and Wishbone regs.
// Assumes a Wishbone classic master on clk_i and open-drain wiring outside.
//
// Behaviour
// - Sleep bits zero: normal, else sleep outputs low
// - Scan drive standby levels follow sleep bits
// - Sleep forces dual pins into scan role
// - Scan-pin bits pick dual pin roles
// - Port bits convert first segment pins
// - Port pin drives high when its bit set
// - Blank bit forces segments off, data kept
// - Pin n uses bits 2n-1 and 2n
// - Bit one lights segment in its phase
// - Key read gives keys then sleep flag
// - Key index is line times five plus sense
// - Segment-role dual pins report keys zero
// - Sleep flag records mode at key press
// - Sleep stops oscillator, key press restarts it
// - Port pins keep driving during sleep
// - Frame rate is oscillator over 512
// - Agreeing scans raise request 800T after start
// - Chip enable high releases key request
`timescale 1ns/1ps
module lcd_key_ctrl_decode
  import lcd_key_pkg::*;
#(
  parameter int OSC_DIV_P = OSC_DIV
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // Pins from outside the clock domain
  input  wire logic        ce_i,
  input  wire logic [4:0]  scan_sense_lines_i,
  // Display and scan pins
  output logic      [42:0] seg_o,
  output logic             dual_scan_seg_pin_a_o,
  output logic             dual_scan_seg_pin_b_o,
  output logic      [3:0]  scan_drive_lines_o,
  output logic             backplane_a_o,
  output logic             backplane_b_o,
  // Open-drain key request and interrupt
  output logic             key_req_do_o,
  output logic             key_req_oe_o,
  output logic             irq_o
);

  logic [6:0]            ctrl_reg;
  logic [DISP_BITS-1:0]  disp_reg;
  logic [1:0]            istat_reg;
  logic [1:0]            imask_reg;
  logic                  ack_reg;
  logic [31:0]           rdat_reg;
  logic                  ce_s1, ce_s2;
  logic [4:0]            sense_s1, sense_s2;
  logic [15:0]           dcnt;
  logic                  tick;
  logic                  osc_run;
  logic [7:0]            bcnt;
  logic                  phase_reg;
  scan_state_t           state_reg;
  logic [9:0]            tcnt;
  logic [5:0]            scnt;
  logic [2:0]            line_reg;
  logic                  pass_reg;
  logic [KEY_BITS-1:0]   acc_a, acc_b;
  logic [KEY_BITS-1:0]   key_reg;
  logic                  sa_reg, sa_cap;
  logic                  req_reg;
  logic [SEG_PINS-1:0]   seg_reg;
  logic [5:0]            drv_reg, drv_next;
  logic                  mode_a_reg, mode_b_reg;
  logic                  bp_a_reg, bp_b_reg;
  logic                  sleep, blank, seg_a, seg_b;
  logic [3:0]            port_en;
  logic [KEY_BITS-1:0]   key_mask;
  logic                  acc, wr, rd_key, agree, latch, start;
  logic [31:0]           bmask;

  assign acc    = cyc_i & stb_i & ~ack_reg;
  assign wr     = acc & we_i;
  assign rd_key = acc & ~we_i & (adr_i == ADDR_KEY);
  assign bmask  = {{8{sel_i[3]}}, {8{sel_i[2]}},
                   {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign ack_o  = ack_reg;
  assign dat_o  = rdat_reg;

  // Mode decode from the control word.
  assign sleep = ctrl_reg[CTL_SLEEP_A] | ctrl_reg[CTL_SLEEP_B];
  assign blank = ctrl_reg[CTL_BLANK];
  assign seg_a = ~sleep &
                 (ctrl_reg[CTL_SCAN_A] | ctrl_reg[CTL_SCAN_B]);
  assign seg_b = ~sleep & ctrl_reg[CTL_SCAN_A];
  always_comb
  begin
    case ({ctrl_reg[CTL_PORT_A], ctrl_reg[CTL_PORT_B]})
      2'b01:   port_en = 4'h3;
      2'b10:   port_en = 4'h7;
      2'b11:   port_en = 4'hF;
      default: port_en = 4'h0;
    endcase
  end
  assign key_mask = {20'hF_FFFF, {5{~seg_b}}, {5{~seg_a}}};

  // Bus handshake: one wait state, ack for every address.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= acc;
  end

  // The whole control word lands in one write, never partly shifted.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= CTRL_RST;
    else if (wr && adr_i == ADDR_CTRL && sel_i[0])
      ctrl_reg <= dat_i[6:0];
  end

  // Display data is not cleared by reset; the segment output register is cleared while reset is held.
  always_ff @(posedge clk_i)
  begin
    if (wr && adr_i == ADDR_DISP0)
      disp_reg[31:0] <= (disp_reg[31:0] & ~bmask) | (dat_i & bmask);
    if (wr && adr_i == ADDR_DISP1)
      disp_reg[63:32] <= (disp_reg[63:32] & ~bmask) | (dat_i & bmask);
    if (wr && adr_i == ADDR_DISP2)
      disp_reg[89:64] <= (disp_reg[89:64] & ~bmask[25:0])
                         | (dat_i[25:0] & bmask[25:0]);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_reg <= 32'h0000_0000;
    else if (acc && !we_i)
    begin
      case (adr_i)
        ADDR_CTRL:  rdat_reg <= {25'h000_0000, ctrl_reg};
        ADDR_DISP0: rdat_reg <= disp_reg[31:0];
        ADDR_DISP1: rdat_reg <= disp_reg[63:32];
        ADDR_DISP2: rdat_reg <= {6'h00, disp_reg[89:64]};
        ADDR_KEY:   rdat_reg <= {req_reg, sa_reg, key_reg};
        ADDR_ISTAT: rdat_reg <= {30'h0000_0000, istat_reg};
        ADDR_IMASK: rdat_reg <= {30'h0000_0000, imask_reg};
        ADDR_STAT:  rdat_reg <= {28'h000_0000, state_reg != ST_IDLE,
                                 osc_run, phase_reg, sleep};
        default:    rdat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Two-flop synchronisers for pins.
  always_ff @(posedge clk_i)
  begin
    ce_s1    <= ce_i;
    ce_s2    <= ce_s1;
    sense_s1 <= scan_sense_lines_i;
    sense_s2 <= sense_s1;
  end

  // Oscillator stand-in: stopped in sleep only while the scan state is ST_IDLE.
  assign osc_run = ~sleep | (state_reg != ST_IDLE);
  assign tick    = osc_run & (dcnt == 16'(OSC_DIV_P - 1));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !osc_run || tick)
      dcnt <= 16'h0000;
    else
      dcnt <= dcnt + 16'h0001;
  end

  // Backplane phase toggles every 256 T, one frame per 512 T.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bcnt      <= 8'h00;
      phase_reg <= 1'b0;
    end
    else if (tick)
    begin
      bcnt <= bcnt + 8'h01;
      if (bcnt == BP_HALF_LAST)
      begin
        bcnt      <= 8'h00;
        phase_reg <= ~phase_reg;
      end
    end
  end

  // Scan sequencing.
  assign agree = (acc_a == acc_b);
  assign latch = state_reg == ST_WAIT && tick && tcnt == REQ_LAST;
  assign start = state_reg == ST_IDLE && (|sense_s2);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ST_IDLE;
      tcnt      <= 10'h000;
      scnt      <= 6'h00;
      line_reg  <= 3'h0;
      pass_reg  <= 1'b0;
      acc_a     <= 30'h0000_0000;
      acc_b     <= 30'h0000_0000;
      sa_cap    <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            state_reg <= ST_SCAN;
            sa_cap    <= sleep;
          end
        end
        ST_SCAN:
        begin
          if (tick)
          begin
            tcnt <= tcnt + 10'h001;
            scnt <= scnt + 6'h01;
            if (scnt == STEP_LAST)
            begin
              scnt <= 6'h00;
              for (int j = 0; j < 6; j++)
              begin
                if (line_reg == 3'(j))
                begin
                  if (pass_reg)
                    acc_b[j*5 +: 5] <= sense_s2;
                  else
                    acc_a[j*5 +: 5] <= sense_s2;
                end
              end
              line_reg <= line_reg + 3'h1;
              if (line_reg == 3'h5)
              begin
                line_reg <= 3'h0;
                pass_reg <= 1'b1;
                if (pass_reg)
                  state_reg <= ST_WAIT;
              end
            end
          end
        end
        ST_WAIT:
        begin
          if (tick)
            tcnt <= tcnt + 10'h001;
          if (latch)
          begin
            tcnt     <= 10'h000;
            pass_reg <= 1'b0;
            if (agree && (|acc_a))
              state_reg <= ST_HOLD;
            else if (agree)
              state_reg <= ST_IDLE;
            else
              state_reg <= ST_SCAN;
          end
        end
        ST_HOLD:
        begin
          // Rescan after the controller has read the key data.
          if (!req_reg)
          begin
            state_reg <= ST_SCAN;
            sa_cap    <= sleep;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Key data, sleep flag and request.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_reg <= 30'h0000_0000;
      sa_reg  <= 1'b0;
      req_reg <= 1'b0;
    end
    else if (latch && agree && (|acc_a))
    begin
      key_reg <= acc_a & key_mask;
      sa_reg  <= sa_cap;
      req_reg <= 1'b1;
    end
    else if (rd_key)
      req_reg <= 1'b0;
  end

  // Open-drain request pin pulls low while pending and CE is low.
  assign key_req_do_o = 1'b0;
  assign key_req_oe_o = req_reg & ~ce_s2;

  // Interrupts: set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      istat_reg <= 2'b00;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_KEYREQ && latch && agree && (|acc_a)) ||
            (i == IRQ_RESCAN && latch && !agree))
          istat_reg[i] <= 1'b1;
        else if (wr && adr_i == ADDR_ISTAT && sel_i[0] && dat_i[i])
          istat_reg[i] <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      imask_reg <= 2'b00;
    else if (wr && adr_i == ADDR_IMASK && sel_i[0])
      imask_reg <= dat_i[1:0];
  end
  assign irq_o = |(istat_reg & imask_reg);

  // Scan drive: one-hot during a scan, standby levels otherwise.
  always_comb
  begin
    if (state_reg == ST_SCAN)
      drv_next = 6'h01 << line_reg;
    else
    begin
      case ({ctrl_reg[CTL_SLEEP_A], ctrl_reg[CTL_SLEEP_B]})
        2'b01:   drv_next = 6'h20;
        2'b10:   drv_next = 6'h30;
        default: drv_next = 6'h3F;
      endcase
    end
  end

  // Segment, port and backplane output registers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seg_reg    <= 45'h0000_0000_0000;
      drv_reg    <= 6'h20;
      mode_a_reg <= 1'b0;
      mode_b_reg <= 1'b0;
      bp_a_reg   <= 1'b0;
      bp_b_reg   <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < SEG_PINS; i++)
      begin
        if (i < 4 && port_en[i])
          seg_reg[i] <= disp_reg[2*i];
        else if (sleep || blank)
          seg_reg[i] <= 1'b0;
        else
          seg_reg[i] <= phase_reg ? disp_reg[2*i+1]
                                  : disp_reg[2*i];
      end
      drv_reg    <= drv_next;
      mode_a_reg <= seg_a;
      mode_b_reg <= seg_b;
      bp_a_reg   <= ~sleep & ~phase_reg;
      bp_b_reg   <= ~sleep & phase_reg;
    end
  end
  assign seg_o                 = seg_reg[42:0];
  assign dual_scan_seg_pin_a_o = mode_a_reg ? seg_reg[43] : drv_reg[0];
  assign dual_scan_seg_pin_b_o = mode_b_reg ? seg_reg[44] : drv_reg[1];
  assign scan_drive_lines_o    = drv_reg[5:2];
  assign backplane_a_o         = bp_a_reg;
  assign backplane_b_o         = bp_b_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_agree_latch;
    latch && agree && (|acc_a);
  endsequence
  // The read edge clears the request; the next edge starts the rescan.
  sequence s_released;
    req_reg ##1 !req_reg ##1 (state_reg == ST_SCAN);
  endsequence

  a_sleep_outputs: assert property (
    sleep |=> !backplane_a_o && !backplane_b_o)
    else $error("Backplanes not low in sleep.");
  a_standby_drive: assert property (
    state_reg != ST_SCAN && !ctrl_reg[CTL_SLEEP_A] && ctrl_reg[CTL_SLEEP_B]
    |=> drv_reg == 6'h20)
    else $error("Standby drive wrong for sleep 01.");
  a_sleep_dual_role: assert property (
    sleep |=> dual_scan_seg_pin_a_o == drv_reg[0]
              && dual_scan_seg_pin_b_o == drv_reg[1])
    else $error("Dual pins not in scan role in sleep.");
  a_port_static: assert property (
    port_en[3] |=> seg_o[3] == $past(disp_reg[6]))
    else $error("Port pin does not follow its bit.");
  a_blank_off: assert property (
    blank && !sleep && port_en == 4'h0 |=> seg_o == 43'h0)
    else $error("Segments lit while blanked.");
  a_frame_half: assert property (
    tick && bcnt == BP_HALF_LAST |=> phase_reg != $past(phase_reg))
    else $error("Backplane phase did not toggle.");
  a_req_raise: assert property (
    s_agree_latch |=> req_reg && state_reg == ST_HOLD)
    else $error("Key request not raised on agreement.");
  a_keys_masked: assert property (
    (s_agree_latch and seg_a) |=> key_reg[4:0] == 5'h00)
    else $error("Masked key bits reported.");
  a_ce_release: assert property (
    ce_s2 |-> !key_req_oe_o)
    else $error("Request driven while chip enable high.");
  a_read_clears: assert property (
    req_reg && rd_key |=> !req_reg)
    else $error("Key read did not clear request.");
  a_wake_scan: assert property (
    start && sleep |=> state_reg == ST_SCAN && osc_run)
    else $error("Key press did not restart oscillator.");
  a_hold_cycle: assert property (
    state_reg == ST_HOLD && rd_key |-> s_released)
    else $error("Request not released after read.");

endmodule : lcd_key_ctrl_decode

// >>> logic/lcd_key_pkg.sv
// Constants, register map and state type for the LCD and key-scan block.
// Assumes a 40 MHz system clock and a nominal 50 kHz scan oscillator.
package lcd_key_pkg;
  // System clock and oscillator timing.
  localparam int CLK_PERIOD_PS = 25000;
  localparam int OSC_PERIOD_PS = 20000000;
  localparam int OSC_DIV       = OSC_PERIOD_PS / CLK_PERIOD_PS;
  // Oscillator periods (T) for scanning and the frame.
  localparam int SCAN_PERIOD_T = 375;
  localparam int REQ_DELAY_T   = 800;
  localparam int FRAME_DIV_T   = 512;
  localparam logic [7:0] BP_HALF_LAST = 8'(FRAME_DIV_T / 2 - 1);
  localparam logic [5:0] STEP_LAST    = 6'(SCAN_PERIOD_T / 6 - 1);
  localparam logic [9:0] REQ_LAST     = 10'(REQ_DELAY_T - 1);
  // Geometry.
  localparam int DISP_BITS = 90;
  localparam int SEG_PINS  = 45;
  localparam int KEY_BITS  = 30;
  // Wishbone byte offsets.
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_DISP0 = 8'h04;
  localparam logic [7:0] ADDR_DISP1 = 8'h08;
  localparam logic [7:0] ADDR_DISP2 = 8'h0C;
  localparam logic [7:0] ADDR_KEY   = 8'h10;
  localparam logic [7:0] ADDR_ISTAT = 8'h14;
  localparam logic [7:0] ADDR_IMASK = 8'h18;
  localparam logic [7:0] ADDR_STAT  = 8'h1C;
  // Control register fields and reset value.
  localparam int CTL_SLEEP_A = 0;
  localparam int CTL_SLEEP_B = 1;
  localparam int CTL_SCAN_A  = 2;
  localparam int CTL_SCAN_B  = 3;
  localparam int CTL_PORT_A  = 4;
  localparam int CTL_PORT_B  = 5;
  localparam int CTL_BLANK   = 6;
  localparam logic [6:0] CTRL_RST = 7'h00;
  // Interrupt status bits.
  localparam int IRQ_KEYREQ  = 0;
  localparam int IRQ_RESCAN  = 1;
  typedef enum {ST_IDLE, ST_SCAN, ST_WAIT, ST_HOLD} scan_state_t;
endpackage : lcd_key_pkg

// >>> test/key_matrix_model.sv
// Key matrix model standing on the block's scan pins.
// Assumes drive line n is drv_i bit n-1 and the bench sets keys_i.
`timescale 1ns/1ps
module key_matrix_model
(
  // Scan side
  input  wire logic [5:0]  drv_i,
  input  wire logic [29:0] keys_i,
  // Sense side
  output logic      [4:0]  sense_o
);
  // Sense pins are pulled down, so an open key reads low, not stale.
  always_comb
  begin
    sense_o = 5'h00;
    for (int i = 0; i < 30; i++)
      if (keys_i[i] && drv_i[i / 5])
        sense_o[i % 5] = 1'b1;
  end
endmodule : key_matrix_model

// >>> test/tb_lcd_key_ctrl_decode.sv
// Self-checking bench for the LCD control decode and key-scan block.
// Assumes the package and the key matrix model are compiled first.
`timescale 1ns/1ps
module tb_lcd_key_ctrl_decode;
  import lcd_key_pkg::*;
  localparam int DIV   = 4;
  localparam int FRAME = FRAME_DIV_T * DIV;
  logic        clk_i  = 1'b0;
  logic        rst_i  = 1'b1;
  logic [7:0]  adr_i  = 8'h00;
  logic [31:0] dat_i  = 32'h0000_0000;
  logic        we_i   = 1'b0;
  logic        cyc_i  = 1'b0;
  logic        stb_i  = 1'b0;
  logic        ce_i   = 1'b0;
  logic [29:0] keys   = 30'h0000_0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [4:0]  sense;
  logic [42:0] seg_o;
  logic        dual_a;
  logic        dual_b;
  logic [3:0]  drv_o;
  logic        bp_a;
  logic        bp_b;
  logic        req_do;
  logic        req_oe;
  logic        irq_o;
  logic [31:0] rd;
  logic [31:0] disp [3];
  logic [5:0]  sdrv [4] = '{6'h3F, 6'h30, 6'h20, 6'h3F};
  int          cv [4]   = '{0, 3, 2, 4};
  int          err_count = 0;
  int          compares  = 0;
  int          n;
  int          c;

  always #12.5 clk_i = ~clk_i;

  lcd_key_ctrl_decode #(.OSC_DIV_P(DIV)) dut_u
  (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
    .dat_o(dat_o), .we_i(we_i), .sel_i(4'hF), .cyc_i(cyc_i),
    .stb_i(stb_i), .ack_o(ack_o), .ce_i(ce_i),
    .scan_sense_lines_i(sense), .seg_o(seg_o),
    .dual_scan_seg_pin_a_o(dual_a), .dual_scan_seg_pin_b_o(dual_b),
    .scan_drive_lines_o(drv_o), .backplane_a_o(bp_a),
    .backplane_b_o(bp_b), .key_req_do_o(req_do),
    .key_req_oe_o(req_oe), .irq_o(irq_o)
  );

  key_matrix_model km_u
  (
    .drv_i({drv_o, dual_b, dual_a}), .keys_i(keys), .sense_o(sense)
  );

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic fail(input string what);
    err_count++;
    $display("MISMATCH %0t timeout %s", $time, what);
    conclude();
  endtask : fail

  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic cycle; read data lands in rd at the acknowledging edge.
  task automatic wb(input logic [7:0] a, input logic w,
                    input logic [31:0] d);
    int i;
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    for (i = 0; i < 20 && ack_o !== 1'b1; i++)
      @(posedge clk_i);
    if (i == 20)
      fail("bus ack");
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rise(output int k);
    k = 0;
    while (bp_a !== 1'b0 && k < 3 * FRAME)
    begin
      @(posedge clk_i);
      k++;
    end
    while (bp_a !== 1'b1 && k < 3 * FRAME)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 3 * FRAME)
      fail("backplane");
  endtask : rise

  function automatic logic dbit(input int k);
    return disp[(k - 1) / 32][(k - 1) % 32];
  endfunction : dbit

  // Samples the middle of each backplane phase, away from its edges.
  task automatic frame_chk(input int conv, input logic blank);
    logic [44:0] e;
    int k;
    rise(k);
    for (int ph = 0; ph < 2; ph++)
    begin
      repeat (ph == 0 ? FRAME / 4 : FRAME / 2) @(posedge clk_i);
      for (int i = 0; i < 45; i++)
        e[i] = blank ? 1'b0 : dbit(2 * i + 1 + ph);
      for (int i = 0; i < conv; i++)
        e[i] = dbit(2 * i + 1);
      chk({dual_b, dual_a, seg_o}, e, "segments");
      chk({bp_a, bp_b}, ph == 0 ? 2'b10 : 2'b01, "backplanes");
    end
  endtask : frame_chk

  task automatic wreq(output int k);
    k = 0;
    while (req_oe !== 1'b1)
    begin
      @(posedge clk_i);
      k++;
      if (k > 6000)
        fail("key request");
    end
  endtask : wreq

  // Presses keys, waits for the request, releases and reads the result.
  task automatic key_run(input logic [29:0] k, input logic [31:0] e);
    @(posedge clk_i);
    keys <= k;
    wreq(c);
    keys <= 30'h0000_0000;
    wb(ADDR_KEY, 1'b0, 32'h0000_0000);
    chk(rd, e, "key word");
    wb(ADDR_ISTAT, 1'b1, 32'h0000_0001);
    // The rescan after the read must end before the next press.
    repeat (3300) @(posedge clk_i);
    chk(req_oe, 0, "idle after rescan");
  endtask : key_run

  initial
  begin
    disp[0] = 32'h3C96_0051;
    disp[1] = 32'hA5C3_0F96;
    disp[2] = 32'h02F0_3C69;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({ack_o, irq_o, req_oe, req_do}, 0, "reset outputs");
    chk({drv_o, dual_b, dual_a}, 6'h3F, "normal standby");
    wb(ADDR_CTRL, 1'b0, 32'h0000_0000);
    chk(rd, CTRL_RST, "ctrl reset");
    wb(8'h20, 1'b0, 32'h0000_0000);
    chk(rd, 0, "unmapped read");
    for (n = 0; n < 3; n++)
      wb(ADDR_DISP0 + 8'(4 * n), 1'b1, disp[n]);
    $display("test reset done");
    for (n = 1; n < 4; n++)
    begin
      wb(ADDR_CTRL, 1'b1, 32'(n) | 32'h0000_003C);
      repeat (4) @(posedge clk_i);
      chk({drv_o, dual_b, dual_a}, sdrv[n], "standby");
      chk({bp_a, bp_b, seg_o[42:4]}, 0, "sleep low");
      chk(seg_o[3:0], 4'b1101, "ports in sleep");
    end
    $display("test sleep done");
    for (n = 0; n < 4; n++)
    begin
      wb(ADDR_CTRL, 1'b1, 32'h0000_000C | (32'(n) << 4));
      frame_chk(cv[n], 1'b0);
    end
    wb(ADDR_CTRL, 1'b1, 32'h0000_004C);
    frame_chk(0, 1'b1);
    wb(ADDR_CTRL, 1'b1, 32'h0000_000C);
    frame_chk(0, 1'b0);
    rise(c);
    rise(c);
    chk(c, FRAME, "frame length");
    $display("test display done");
    wb(ADDR_CTRL, 1'b1, 32'h0000_0000);
    wb(ADDR_IMASK, 1'b1, 32'h0000_0000);
    @(posedge clk_i);
    keys <= 30'h0000_2000;
    wreq(c);
    chk(c >= 3200 && c <= 3220, 1, "request delay");
    chk(irq_o, 0, "masked irq");
    wb(ADDR_IMASK, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 1, "unmasked irq");
    ce_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(req_oe, 0, "ce releases");
    ce_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk(req_oe, 1, "request back");
    keys <= 30'h0000_0000;
    wb(ADDR_KEY, 1'b0, 32'h0000_0000);
    chk(rd, 32'h8000_2000, "normal key");
    wb(ADDR_ISTAT, 1'b1, 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    chk(irq_o, 0, "irq cleared");
    repeat (3300) @(posedge clk_i);
    chk(req_oe, 0, "idle after read");
    wb(ADDR_CTRL, 1'b1, 32'h0000_000C);
    // Segment pin a stays high, so key 3 shows on every scanned line.
    key_run(30'h0008_0004, 32'h884A_1000);
    wb(ADDR_CTRL, 1'b1, 32'h0000_0003);
    key_run(30'h0200_0000, 32'hC200_0000);
    $display("test keys done");
    conclude();
  end
endmodule : tb_lcd_key_ctrl_decode
